// ---- rtl/ddrc_pkg.sv ----
// package for the dual domain reset control block
package ddrc_pkg;

	// ==========================================================
	// timing counts
	// ==========================================================
	localparam int unsigned DDRC_CLK_MHZ       = 100;
	localparam int unsigned DDRC_HOLD_NS       = 100;
	localparam int unsigned DDRC_HOLD_CYC      = (DDRC_HOLD_NS * DDRC_CLK_MHZ + 999) / 1000;
	localparam int unsigned DDRC_CNT_W         = 8;
	localparam int unsigned DDRC_SYNC_STAGES   = 2;

	// ==========================================================
	// reset values
	// ==========================================================
	localparam logic        DDRC_RST_ASSERTED  = 1'b0;
	localparam logic        DDRC_RST_RELEASED  = 1'b1;

	// ==========================================================
	// sequencer states
	// ==========================================================
	typedef enum logic [1:0] {
		DDRC_ST_POR  = 2'b00,
		DDRC_ST_MCU  = 2'b01,
		DDRC_ST_MAIN = 2'b10,
		DDRC_ST_RUN  = 2'b11
	} ddrc_state_t;

	// ==========================================================
	// status carrier
	// ==========================================================
	typedef struct packed {
		logic por_n;
		logic mcu_n;
		logic main_n;
	} ddrc_status_t;

endpackage : ddrc_pkg

// ---- rtl/ddrc_sync.sv ----
// two flop level synchroniser with asynchronous assert
`timescale 1ns/1ps
module ddrc_sync
	import ddrc_pkg::*;
#(
	parameter logic RESET_VAL = 1'b0
) (
	input  wire logic clk,
	input  wire logic rst_n,
	input  wire logic d,
	output logic      q
);

	logic meta_r;
	logic meta_nxt;
	logic q_r;
	logic q_nxt;

	always_comb begin
		meta_nxt = d;
		q_nxt    = meta_r;
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			meta_r <= RESET_VAL;
			q_r    <= RESET_VAL;
		end else begin
			meta_r <= meta_nxt;
			q_r    <= q_nxt;
		end
	end

	assign q = q_r;

endmodule : ddrc_sync

// ---- rtl/ddrc_top.sv ----
// dual domain reset control top
// Overview of operation
// (RQ1) A failing or unstable supply reaches the block as a power-on reset and resets all.
// (RQ2) Power-on reset asserted resets both the controller domain and the main domain.
// (RQ3) The power-on reset state is shown on its own status output.
// (RQ4) The controller warm reset input resets without raising a power-on reset.
// (RQ5) While the controller warm reset is low, both domains are held in reset.
// (RQ6) The controller status output shows whether that domain is in reset.
// (RQ7) The main warm reset request resets only the main domain.
// (RQ8) The main status output tracks the main domain reset state.
// (RQ9) The carrier holds the main warm reset request high when no reset is intended.
// (RQ10) Inputs from other domains are synchronised before use.
// (RQ11) All reset inputs and status outputs are active low.
`timescale 1ns/1ps
module ddrc_top
	import ddrc_pkg::*;
#(
	parameter int unsigned HOLD_CYC = DDRC_HOLD_CYC
) (
	input  wire logic clk,
	input  wire logic rst_n,
	input  wire logic power_on_reset_in_n,
	input  wire logic mcu_domain_warm_reset_in_n,
	input  wire logic main_domain_warm_reset_req_n,
	output logic      power_on_reset_status_out_n,
	output logic      mcu_domain_reset_status_out_n,
	output logic      main_domain_reset_status_out_n
);

	// ==========================================================
	// input synchronisers
	// ==========================================================
	logic por_s;
	logic mcu_s;
	logic main_s;

	// (RQ10) sync power-on
	ddrc_sync #(.RESET_VAL(DDRC_RST_ASSERTED)) u_sync_por (
		.clk   (clk),
		.rst_n (rst_n),
		.d     (power_on_reset_in_n),
		.q     (por_s)
	);

	// (RQ10) sync mcu warm
	ddrc_sync #(.RESET_VAL(DDRC_RST_ASSERTED)) u_sync_mcu (
		.clk   (clk),
		.rst_n (rst_n),
		.d     (mcu_domain_warm_reset_in_n),
		.q     (mcu_s)
	);

	// (RQ10) sync main warm
	ddrc_sync #(.RESET_VAL(DDRC_RST_ASSERTED)) u_sync_main (
		.clk   (clk),
		.rst_n (rst_n),
		.d     (main_domain_warm_reset_req_n),
		.q     (main_s)
	);

	// ==========================================================
	// sequencer
	// ==========================================================
	ddrc_state_t             state_r;
	ddrc_state_t             state_nxt;
	logic [DDRC_CNT_W-1:0]   cnt_r;
	logic [DDRC_CNT_W-1:0]   cnt_nxt;
	ddrc_status_t            stat_r;
	ddrc_status_t            stat_nxt;
	logic                    hold_done;

	assign hold_done = (cnt_r >= DDRC_CNT_W'(HOLD_CYC - 1));

	always_comb begin
		state_nxt = state_r;
		cnt_nxt   = hold_done ? cnt_r : cnt_r + 1'b1;
		// (RQ1) (RQ2) power-on resets all
		if (!por_s) begin
			state_nxt = DDRC_ST_POR;
			cnt_nxt   = '0;
		// (RQ4) (RQ5) warm reset both
		end else if (!mcu_s) begin
			if (state_r != DDRC_ST_POR) begin
				state_nxt = DDRC_ST_MCU;
			end
			cnt_nxt = '0;
		// (RQ7) main only reset
		end else if (!main_s) begin
			if (state_r == DDRC_ST_RUN || state_r == DDRC_ST_MAIN || hold_done) begin
				state_nxt = DDRC_ST_MAIN;
				cnt_nxt   = '0;
			end
		end else begin
			unique case (state_r)
				DDRC_ST_POR,
				DDRC_ST_MCU,
				DDRC_ST_MAIN: begin
					if (hold_done) begin
						state_nxt = DDRC_ST_RUN;
					end
				end
				DDRC_ST_RUN: begin
					state_nxt = DDRC_ST_RUN;
				end
			endcase
		end
		// (RQ3) (RQ6) (RQ8) (RQ11) status decode
		stat_nxt.por_n  = (state_nxt != DDRC_ST_POR);
		stat_nxt.mcu_n  = (state_nxt == DDRC_ST_RUN) || (state_nxt == DDRC_ST_MAIN);
		stat_nxt.main_n = (state_nxt == DDRC_ST_RUN);
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			state_r <= DDRC_ST_POR;
			cnt_r   <= '0;
			stat_r  <= '0;
		end else begin
			state_r <= state_nxt;
			cnt_r   <= cnt_nxt;
			stat_r  <= stat_nxt;
		end
	end

	assign power_on_reset_status_out_n    = stat_r.por_n;
	assign mcu_domain_reset_status_out_n  = stat_r.mcu_n;
	assign main_domain_reset_status_out_n = stat_r.main_n;

	// ==========================================================
	// assertions
	// ==========================================================
	// (RQ2) power-on resets all
	property p_por_all;
		@(posedge clk) disable iff (!rst_n)
		!por_s |=> !power_on_reset_status_out_n && !mcu_domain_reset_status_out_n
			&& !main_domain_reset_status_out_n;
	endproperty
	a_por_all: assert property (p_por_all) else $error("por did not reset all"); // (RQ2)

	// (RQ3) power-on status held
	property p_por_status;
		@(posedge clk) disable iff (!rst_n)
		$rose(por_s) |=> !power_on_reset_status_out_n;
	endproperty
	a_por_status: assert property (p_por_status) else $error("por status early"); // (RQ3)

	// (RQ3) status follows input
	property p_por_track;
		@(posedge clk) disable iff (!rst_n)
		power_on_reset_status_out_n |-> $past(por_s);
	endproperty
	a_por_track: assert property (p_por_track) else $error("por status high in por"); // (RQ3)

	// (RQ1) supply fail resets
	property p_supply_fail;
		@(posedge clk) disable iff (!rst_n)
		$fell(power_on_reset_in_n) |-> ##3 !power_on_reset_status_out_n;
	endproperty
	a_supply_fail: assert property (p_supply_fail) else $error("supply fail no reset"); // (RQ1)

	// (RQ4) warm keeps por
	property p_warm_no_por;
		@(posedge clk) disable iff (!rst_n)
		por_s && power_on_reset_status_out_n |=> power_on_reset_status_out_n;
	endproperty
	a_warm_no_por: assert property (p_warm_no_por) else $error("warm raised por"); // (RQ4)

	// (RQ5) warm resets both
	property p_mcu_both;
		@(posedge clk) disable iff (!rst_n)
		!mcu_s |=> !mcu_domain_reset_status_out_n && !main_domain_reset_status_out_n;
	endproperty
	a_mcu_both: assert property (p_mcu_both) else $error("mcu warm not both"); // (RQ5)

	// (RQ6) mcu status tracks
	property p_mcu_stat;
		@(posedge clk) disable iff (!rst_n)
		mcu_domain_reset_status_out_n |-> $past(por_s) && $past(mcu_s);
	endproperty
	a_mcu_stat: assert property (p_mcu_stat) else $error("mcu status wrong"); // (RQ6)

	// (RQ7) main leaves mcu
	property p_main_only;
		@(posedge clk) disable iff (!rst_n)
		por_s && mcu_s && !main_s && mcu_domain_reset_status_out_n
			|=> mcu_domain_reset_status_out_n && !main_domain_reset_status_out_n;
	endproperty
	a_main_only: assert property (p_main_only) else $error("main req hit mcu"); // (RQ7)

	// (RQ7) mcu runs past main
	property p_mcu_past_main;
		@(posedge clk) disable iff (!rst_n)
		!mcu_domain_reset_status_out_n && por_s && mcu_s && !main_s && hold_done
			|=> mcu_domain_reset_status_out_n && !main_domain_reset_status_out_n;
	endproperty
	a_mcu_past_main: assert property (p_mcu_past_main) else $error("main req held mcu"); // (RQ7)

	// (RQ8) main release
	property p_main_rel;
		@(posedge clk) disable iff (!rst_n)
		!main_domain_reset_status_out_n && por_s && mcu_s && main_s && hold_done
			|=> main_domain_reset_status_out_n;
	endproperty
	a_main_rel: assert property (p_main_rel) else $error("main not released"); // (RQ8)

	// (RQ8) main status tracks
	property p_main_track;
		@(posedge clk) disable iff (!rst_n)
		main_domain_reset_status_out_n |-> $past(por_s) && $past(mcu_s) && $past(main_s);
	endproperty
	a_main_track: assert property (p_main_track) else $error("main status high in reset"); // (RQ8)

	// (RQ10) sync latency
	property p_sync_lat;
		@(posedge clk) disable iff (!rst_n)
		$fell(main_domain_warm_reset_req_n) ##1 !main_domain_warm_reset_req_n |=> !main_s;
	endproperty
	a_sync_lat: assert property (p_sync_lat) else $error("sync latency wrong"); // (RQ10)

	c_por:  cover property (@(posedge clk) disable iff (!rst_n) $rose(power_on_reset_status_out_n));
	c_mcu:  cover property (@(posedge clk) disable iff (!rst_n) state_r == DDRC_ST_MCU);
	c_main: cover property (@(posedge clk) disable iff (!rst_n)
		state_r == DDRC_ST_MAIN && mcu_domain_reset_status_out_n);
	c_mcu_main: cover property (@(posedge clk) disable iff (!rst_n)
		state_r == DDRC_ST_MCU ##1 state_r == DDRC_ST_MAIN);
	c_por_main: cover property (@(posedge clk) disable iff (!rst_n)
		state_r == DDRC_ST_POR ##1 state_r == DDRC_ST_MAIN);

endmodule : ddrc_top

// ---- tb/ddrc_carrier.sv ----
// carrier board model driving the reset pins of the block
`timescale 1ns/1ps
module ddrc_carrier
	import ddrc_pkg::*;
(
	input  wire logic por_req,
	input  wire logic mcu_req,
	input  wire logic main_req,
	output logic      por_n,
	output logic      mcu_n,
	output logic      main_n
);
	// ==========================================================
	// pin drive
	// ==========================================================
	// low asserts
	assign por_n  = por_req ? DDRC_RST_ASSERTED : DDRC_RST_RELEASED;
	assign mcu_n  = mcu_req ? DDRC_RST_ASSERTED : DDRC_RST_RELEASED;
	assign main_n = main_req ? DDRC_RST_ASSERTED : DDRC_RST_RELEASED;
endmodule : ddrc_carrier

// ---- tb/ddrc_top_tb.sv ----
// testbench for the dual domain reset control block
`timescale 1ns/1ps
module ddrc_top_tb;
	import ddrc_pkg::*;
	logic         clk;
	logic         rst_n;
	logic         por_req;
	logic         mcu_req;
	logic         main_req;
	logic         por_n;
	logic         mcu_n;
	logic         main_n;
	logic         s_por_n;
	logic         s_mcu_n;
	logic         s_main_n;
	ddrc_status_t st;
	int           bad_count = 0;
	int           cmp_count = 0;
	int           cyc = 0;

	assign st = {s_por_n, s_mcu_n, s_main_n};

	ddrc_carrier i_ddrc_carrier (.por_req(por_req), .mcu_req(mcu_req), .main_req(main_req),
		.por_n(por_n), .mcu_n(mcu_n), .main_n(main_n));

	ddrc_top #(.HOLD_CYC(2)) i_ddrc_top (.clk(clk), .rst_n(rst_n),
		.power_on_reset_in_n(por_n), .mcu_domain_warm_reset_in_n(mcu_n),
		.main_domain_warm_reset_req_n(main_n), .power_on_reset_status_out_n(s_por_n),
		.mcu_domain_reset_status_out_n(s_mcu_n), .main_domain_reset_status_out_n(s_main_n));

	// ==========================================================
	// clock and timeout
	// ==========================================================
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 3000) begin
			bad_count++;
			test_done();
		end
	end

	// ==========================================================
	// helpers
	// ==========================================================
	task automatic drive(input logic p, input logic m, input logic a);
		@(posedge clk);
		por_req  <= p;
		mcu_req  <= m;
		main_req <= a;
	endtask : drive

	task automatic check_st(input ddrc_status_t exp, input int hold, input string what);
		int n;
		n = 0;
		while (st !== exp && n < 20) begin
			@(posedge clk);
			#1;
			n++;
		end
		n = 0;
		while (st === exp && n < hold) begin
			@(posedge clk);
			#1;
			n++;
		end
		cmp_count++;
		if (st !== exp) begin
			bad_count++;
			$display("[FAIL] %s expected %b seen %b", what, exp, st);
		end
	endtask : check_st

	task automatic test_done;
		$display("comparisons %0d mismatches %0d", cmp_count, bad_count);
		if (bad_count == 0 && cmp_count > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask : test_done

	// ==========================================================
	// scenarios
	// ==========================================================
	task automatic t_power_on;
		drive(1'b1, 1'b0, 1'b0);
		check_st(3'b000, 6, "power on all low");
		drive(1'b0, 1'b0, 1'b0);
		check_st(3'b111, 0, "power on release");
	endtask : t_power_on

	task automatic t_mcu_warm;
		drive(1'b0, 1'b1, 1'b0);
		check_st(3'b100, 8, "warm both low");
		drive(1'b0, 1'b0, 1'b0);
		check_st(3'b111, 0, "warm release");
	endtask : t_mcu_warm

	task automatic t_main_req;
		drive(1'b0, 1'b0, 1'b1);
		check_st(3'b110, 8, "main only low");
		drive(1'b0, 1'b1, 1'b1);
		check_st(3'b100, 4, "warm over main");
		drive(1'b0, 1'b0, 1'b1);
		check_st(3'b110, 4, "main after warm");
		drive(1'b0, 1'b0, 1'b0);
		check_st(3'b111, 0, "main release");
	endtask : t_main_req

	task automatic t_por_over_main;
		drive(1'b0, 1'b0, 1'b1);
		check_st(3'b110, 0, "main before power on");
		drive(1'b1, 1'b0, 1'b1);
		check_st(3'b000, 4, "power on over main");
		drive(1'b0, 1'b0, 1'b1);
		check_st(3'b110, 4, "main after power on");
		drive(1'b0, 1'b0, 1'b0);
		check_st(3'b111, 0, "all release");
	endtask : t_por_over_main

	// ==========================================================
	// main sequence
	// ==========================================================
	initial begin
		rst_n    = 1'b0;
		por_req  = 1'b0;
		mcu_req  = 1'b0;
		main_req = 1'b0;
		repeat (12) @(posedge clk);
		check_st(3'b000, 0, "in reset");
		rst_n <= 1'b1;
		check_st(3'b111, 0, "after reset");
		t_power_on();
		t_mcu_warm();
		t_main_req();
		t_por_over_main();
		test_done();
	end
endmodule : ddrc_top_tb
